// ==== adoc_params.svh ====
// constants for the converter calibration control block
// Overview of operation
// - calibration pin high makes the next chip-select fall start a calibration
// - a calibration lasts one chip-select fall plus nineteen serial clock cycles
// - calibration repeats every cycle while the calibration pin stays high
// - calibration pin rising mid-conversion marks that conversion corrupted
// - chip select falling too soon after pin rise gives an inaccurate calibration
// - after a full held cycle calibration ends at the nineteenth clock
// - first chip-select fall after pin low starts a normal dual conversion
// - writing the control calibration bit calibrates next cycle, corrupts current
// - calibration converts shorted inputs and stores each offset separately
// - stored offset is subtracted from every later result of that converter
// - gain selection changes leave the stored offsets untouched
// - correctable offset limited to plus or minus 500 codes
// - host may write offset registers directly; device subtracts them
// - each converter has its own gain correction register
// - gain register is sign bit plus six magnitude bits
// - each magnitude step changes the multiplier by one part in 4096
// - all zeros in a gain register gives a multiplier of exactly one
// - sign zero gives one minus magnitude/4096, sign one gives one plus
// - write is four address and twelve data bits over seventeen clocks
// - addresses 0010/0011 select offsets, 0100/0101 select gains of A/B
// - all registers clear to zero at reset
`ifndef ADOC_PARAMS_SVH
`define ADOC_PARAMS_SVH

`define ADOC_CLK_MHZ 10
`define ADOC_CAL_SETUP_NS 100
`define ADOC_CODE_W 14
`define ADOC_OFF_W 12
`define ADOC_GAIN_W 7
`define ADOC_CNT_W 6
`define ADOC_CNT_MAX 6'h3F
`define ADOC_DATA_FALLS 6'h10
`define ADOC_CONV_LAST 6'h12
`define ADOC_OUT_LAST 6'h2E
`define ADOC_ADDR_CTRL 4'h1
`define ADOC_ADDR_OFF_A 4'h2
`define ADOC_ADDR_OFF_B 4'h3
`define ADOC_ADDR_GAIN_A 4'h4
`define ADOC_ADDR_GAIN_B 4'h5
`define ADOC_ADDR_RESULT 4'h0
`define ADOC_CTRL_CAL_BIT 4
`define ADOC_CTRL_RD_MSB 11
`define ADOC_CTRL_RD_LSB 8
`define ADOC_CTRL_PGA_MSB 3
`define ADOC_CTRL_RESET 12'h000
`define ADOC_OFF_RESET 12'h000
`define ADOC_GAIN_RESET 7'h00
`define ADOC_OFF_LIMIT 11'h1F4
`define ADOC_GAIN_UNITY 14'h1000
`define ADOC_GAIN_SHIFT 12
`define ADOC_CODE_MAX 18'h01FFF
`define ADOC_CODE_MIN 18'h3E000

`endif

// ==== adoc_pkg.sv ====
// types shared by the calibration control block
package adoc_pkg;
    typedef enum logic [1:0] {CYC_IDLE, CYC_CONVERT, CYC_CALIBRATE} adoc_cycle_type;
    typedef logic signed [13:0] adoc_code_type;
endpackage : adoc_pkg

// ==== adoc_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module adoc_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : adoc_sync
`default_nettype wire

// ==== adoc_corrector.sv ====
// offset subtraction, gain multiply and clip for one converter
`timescale 1ns/1ps
`default_nettype none
`include "adoc_params.svh"
module adoc_corrector
    import adoc_pkg::*;
#(
    parameter int CODE_W = `ADOC_CODE_W,
    parameter int OFF_W = `ADOC_OFF_W,
    parameter int GAIN_W = `ADOC_GAIN_W
) (
    input wire logic [CODE_W-1:0] raw_code,
    input wire logic [OFF_W-1:0] offset,
    input wire logic [GAIN_W-1:0] gain,
    output logic [CODE_W-1:0] corr_code
);
    if (CODE_W != 14 || OFF_W != 12 || GAIN_W != 7) begin : g_chk
        $error("adoc_corrector: widths must be 14/12/7");
    end

    // offset held as sign plus magnitude
    wire logic signed [14:0] off_mag = $signed({4'h0, offset[10:0]});
    wire logic signed [14:0] off_val = offset[11] ? -off_mag : off_mag;
    wire logic signed [14:0] diff = $signed({raw_code[13], raw_code}) - off_val;
    wire logic [13:0] gmag = {8'h00, gain[5:0]};
    wire logic [13:0] factor = gain[6] ? (`ADOC_GAIN_UNITY + gmag)
                                       : (`ADOC_GAIN_UNITY - gmag);
    wire logic signed [29:0] prod = diff * $signed({1'b0, factor});
    wire logic signed [17:0] scaled = prod[29:12];
    wire logic too_high = scaled > $signed(`ADOC_CODE_MAX);
    wire logic too_low = scaled < $signed(`ADOC_CODE_MIN);
    assign corr_code = too_high ? 14'h1FFF : too_low ? 14'h2000 : scaled[13:0];
endmodule : adoc_corrector
`default_nettype wire

// ==== adoc_top.sv ====
// calibration control: serial register port, cycle timing, correction
`timescale 1ns/1ps
`default_nettype none
`include "adoc_params.svh"
module adoc_top
    import adoc_pkg::*;
#(
    parameter int CAL_SETUP_NS = `ADOC_CAL_SETUP_NS
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic cal_req,
    input wire logic serial_config_in,
    input wire logic [13:0] raw_code_a,
    input wire logic [13:0] raw_code_b,
    output logic serial_out_a,
    output logic serial_out_a_oe,
    output logic serial_out_b,
    output logic serial_out_b_oe,
    output logic short_inputs,
    output logic [3:0] pga_gain_sel,
    output logic [13:0] result_a,
    output logic [13:0] result_b,
    output logic result_valid,
    output logic conv_corrupt,
    output logic cal_done,
    output logic cal_inaccurate
);
    localparam int CAL_SETUP_CYC = (CAL_SETUP_NS * `ADOC_CLK_MHZ + 999) / 1000;
    if (CAL_SETUP_CYC > 250) begin : g_chk
        $error("adoc_top: calibration setup time too long for its counter");
    end

    // ------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------
    logic [3:0] pins_s;
    logic sclk_d_reg;
    logic cs_d_reg;
    logic cal_d_reg;

    adoc_sync #(.W(4)) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in({sclk, cs_n, cal_req, serial_config_in}),
        .sync_out(pins_s)
    );

    wire logic sclk_s = pins_s[3];
    wire logic cs_n_s = pins_s[2];
    wire logic cal_s = pins_s[1];
    wire logic din_s = pins_s[0];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b0;
            cal_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_d_reg <= cs_n_s;
            cal_d_reg <= cal_s;
        end
    end

    wire logic cs_fall = cs_d_reg & ~cs_n_s;
    wire logic cs_rise = ~cs_d_reg & cs_n_s;
    wire logic cal_rise = cal_s & ~cal_d_reg;
    // an sclk fall coinciding with the cs fall is not counted
    wire logic sclk_fall = sclk_d_reg & ~sclk_s & ~cs_n_s & ~cs_fall;

    // ------------------------------------------------------------
    // falling-edge counter and register write shifter
    // ------------------------------------------------------------
    logic [5:0] fall_cnt_reg;
    logic [15:0] shift_in_reg;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fall_cnt_reg <= '0;
        end else if (cs_fall) begin
            fall_cnt_reg <= '0;
        end else if (sclk_fall && fall_cnt_reg != `ADOC_CNT_MAX) begin
            fall_cnt_reg <= fall_cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            shift_in_reg <= '0;
        end else if (sclk_fall && fall_cnt_reg < `ADOC_DATA_FALLS) begin
            shift_in_reg <= {shift_in_reg[14:0], din_s};
        end
    end

    wire logic wr_evt = sclk_fall && fall_cnt_reg == `ADOC_DATA_FALLS;
    wire logic done_evt = sclk_fall && fall_cnt_reg == `ADOC_CONV_LAST;
    wire logic [3:0] wr_addr = shift_in_reg[15:12];
    wire logic [11:0] wr_data = shift_in_reg[11:0];
    wire logic wr_ctrl = wr_evt && wr_addr == `ADOC_ADDR_CTRL;
    wire logic wr_off_a = wr_evt && wr_addr == `ADOC_ADDR_OFF_A;
    wire logic wr_off_b = wr_evt && wr_addr == `ADOC_ADDR_OFF_B;
    wire logic wr_gain_a = wr_evt && wr_addr == `ADOC_ADDR_GAIN_A;
    wire logic wr_gain_b = wr_evt && wr_addr == `ADOC_ADDR_GAIN_B;
    wire logic wr_cal = wr_ctrl && wr_data[`ADOC_CTRL_CAL_BIT];

    // ------------------------------------------------------------
    // conversion cycle control
    // ------------------------------------------------------------
    adoc_cycle_type cycle_reg;
    logic cal_pend_reg;
    logic corrupt_reg;
    logic early_reg;
    logic [7:0] setup_cnt_reg;

    wire logic start_cal = cal_s | cal_pend_reg;
    wire logic busy = cycle_reg != CYC_IDLE;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            setup_cnt_reg <= '0;
        end else if (!cal_s) begin
            setup_cnt_reg <= '0;
        end else if (setup_cnt_reg < 8'(CAL_SETUP_CYC)) begin
            setup_cnt_reg <= setup_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cycle_reg <= CYC_IDLE;
        end else if (cs_fall) begin
            cycle_reg <= start_cal ? CYC_CALIBRATE : CYC_CONVERT;
        end else if (done_evt || cs_rise) begin
            cycle_reg <= CYC_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cal_pend_reg <= 1'b0;
        end else if (wr_cal) begin
            cal_pend_reg <= 1'b1;
        end else if (cs_fall) begin
            cal_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            corrupt_reg <= 1'b0;
            early_reg <= 1'b0;
        end else if (cs_fall) begin
            corrupt_reg <= 1'b0;
            early_reg <= cal_s && setup_cnt_reg < 8'(CAL_SETUP_CYC);
        end else if ((cal_rise && busy) || wr_cal) begin
            corrupt_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [11:0] ctrl_reg;
    logic [11:0] off_a_reg;
    logic [11:0] off_b_reg;
    logic [6:0] gain_a_reg;
    logic [6:0] gain_b_reg;

    // measured two's-complement code to sign-magnitude, clamped
    function automatic logic [11:0] meas_to_off(input logic [13:0] code);
        logic [13:0] mag;
        mag = code[13] ? 14'(-code) : code;
        if (mag > {3'h0, `ADOC_OFF_LIMIT}) begin
            mag = {3'h0, `ADOC_OFF_LIMIT};
        end
        return {code[13], mag[10:0]};
    endfunction : meas_to_off

    wire logic [11:0] meas_off_a = meas_to_off(raw_code_a);
    wire logic [11:0] meas_off_b = meas_to_off(raw_code_b);
    wire logic cal_store = done_evt && cycle_reg == CYC_CALIBRATE && !early_reg;
    // written offsets are limited the same way as measured ones
    wire logic [11:0] wr_off = (wr_data[10:0] > `ADOC_OFF_LIMIT)
                               ? {wr_data[11], `ADOC_OFF_LIMIT} : wr_data;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_reg <= `ADOC_CTRL_RESET;
            off_a_reg <= `ADOC_OFF_RESET;
            off_b_reg <= `ADOC_OFF_RESET;
            gain_a_reg <= `ADOC_GAIN_RESET;
            gain_b_reg <= `ADOC_GAIN_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wr_data;
            end
            if (cal_store) begin
                off_a_reg <= meas_off_a;
                off_b_reg <= meas_off_b;
            end else begin
                if (wr_off_a) begin
                    off_a_reg <= wr_off;
                end
                if (wr_off_b) begin
                    off_b_reg <= wr_off;
                end
            end
            if (wr_gain_a) begin
                gain_a_reg <= wr_data[11:5];
            end
            if (wr_gain_b) begin
                gain_b_reg <= wr_data[11:5];
            end
        end
    end

    // ------------------------------------------------------------
    // correction and result capture
    // ------------------------------------------------------------
    logic [13:0] corr_a;
    logic [13:0] corr_b;

    adoc_corrector u_corr_a (
        .raw_code(raw_code_a),
        .offset(off_a_reg),
        .gain(gain_a_reg),
        .corr_code(corr_a)
    );

    adoc_corrector u_corr_b (
        .raw_code(raw_code_b),
        .offset(off_b_reg),
        .gain(gain_b_reg),
        .corr_code(corr_b)
    );

    wire logic conv_done = done_evt && cycle_reg == CYC_CONVERT;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            result_a <= '0;
            result_b <= '0;
            result_valid <= 1'b0;
            conv_corrupt <= 1'b0;
            cal_done <= 1'b0;
            cal_inaccurate <= 1'b0;
        end else begin
            result_valid <= conv_done && !corrupt_reg;
            conv_corrupt <= conv_done && corrupt_reg;
            cal_done <= cal_store;
            cal_inaccurate <= done_evt && cycle_reg == CYC_CALIBRATE && early_reg;
            if (conv_done && !corrupt_reg) begin
                result_a <= corr_a;
                result_b <= corr_b;
            end
        end
    end

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    wire logic [3:0] rd_sel = ctrl_reg[`ADOC_CTRL_RD_MSB:`ADOC_CTRL_RD_LSB];
    wire logic [13:0] rb_word = (rd_sel == `ADOC_ADDR_CTRL) ? {2'h0, ctrl_reg}
                              : (rd_sel == `ADOC_ADDR_OFF_A) ? {2'h0, off_a_reg}
                              : (rd_sel == `ADOC_ADDR_OFF_B) ? {2'h0, off_b_reg}
                              : (rd_sel == `ADOC_ADDR_GAIN_A) ? {7'h00, gain_a_reg}
                              : (rd_sel == `ADOC_ADDR_GAIN_B) ? {7'h00, gain_b_reg}
                              : corr_a;
    wire logic [13:0] word_a = (rd_sel == `ADOC_ADDR_RESULT) ? corr_a : rb_word;
    wire logic out_stop = cs_n_s || (sclk_fall && fall_cnt_reg == `ADOC_OUT_LAST);
    logic [27:0] sh_a_reg;
    logic [27:0] sh_b_reg;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sh_a_reg <= '0;
            sh_b_reg <= '0;
            serial_out_a <= 1'b0;
            serial_out_b <= 1'b0;
            serial_out_a_oe <= 1'b0;
            serial_out_b_oe <= 1'b0;
        end else if (out_stop) begin
            serial_out_a_oe <= 1'b0;
            serial_out_b_oe <= 1'b0;
        end else if (done_evt) begin
            serial_out_a <= word_a[13];
            serial_out_b <= corr_b[13];
            sh_a_reg <= {word_a[12:0], corr_b, 1'b0};
            sh_b_reg <= {corr_b[12:0], corr_a, 1'b0};
            serial_out_a_oe <= 1'b1;
            serial_out_b_oe <= 1'b1;
        end else if (sclk_fall && serial_out_a_oe) begin
            serial_out_a <= sh_a_reg[27];
            serial_out_b <= sh_b_reg[27];
            sh_a_reg <= {sh_a_reg[26:0], 1'b0};
            sh_b_reg <= {sh_b_reg[26:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            short_inputs <= 1'b0;
            pga_gain_sel <= '0;
        end else begin
            short_inputs <= cs_fall ? start_cal : (busy && cycle_reg == CYC_CALIBRATE);
            pga_gain_sel <= ctrl_reg[`ADOC_CTRL_PGA_MSB:0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_cal_cycle_end;
        cycle_reg == CYC_CALIBRATE && done_evt && !early_reg;
    endsequence

    sequence s_clean_conv;
        conv_done && !corrupt_reg && gain_a_reg == 7'h00 && off_a_reg == 12'h000;
    endsequence

    a_cal_start_pin: assert property (
        cs_fall && cal_s |=> cycle_reg == CYC_CALIBRATE ##1 short_inputs)
        else $error("calibration did not start on cs fall");
    a_cycle_end: assert property (
        done_evt |=> cycle_reg == CYC_IDLE && fall_cnt_reg == 6'h13)
        else $error("cycle did not end at the nineteenth fall");
    a_normal_conv: assert property (
        cs_fall && !cal_s && !cal_pend_reg |=> cycle_reg == CYC_CONVERT)
        else $error("normal conversion not started");
    a_mid_corrupt: assert property (
        cycle_reg == CYC_CONVERT && cal_rise && !cs_fall |=> corrupt_reg && !result_valid)
        else $error("mid-conversion calibration request not recorded");
    a_cal_bit: assert property (
        wr_cal ##1 (!cs_fall)[*1] |-> cal_pend_reg && corrupt_reg)
        else $error("control calibration bit not honoured");
    a_offset_store: assert property (
        s_cal_cycle_end |=> off_a_reg == $past(meas_off_a) ##0 off_b_reg == $past(meas_off_b)
        ##0 cal_done)
        else $error("calibration offsets not stored");
    a_offset_keep: assert property (
        !cal_store && !wr_off_a |=> $stable(off_a_reg))
        else $error("offset changed without cause");
    a_offset_range: assert property (
        off_a_reg[10:0] <= `ADOC_OFF_LIMIT && off_b_reg[10:0] <= `ADOC_OFF_LIMIT)
        else $error("offset beyond limit");
    a_unity_pass: assert property (
        s_clean_conv |=> result_valid && result_a == $past(raw_code_a))
        else $error("zero gain and offset altered the result");
    a_gain_write: assert property (
        wr_gain_b |=> gain_b_reg == $past(shift_in_reg[11:5]) ##1 $stable(gain_a_reg))
        else $error("gain register write wrong");
endmodule : adoc_top
`default_nettype wire

// ==== adoc_host.sv ====
// serial host model: frames, register writes, calibration pin
`timescale 1ns/1ps
`default_nettype none
module adoc_host (
    input wire logic core_clk,
    input wire logic serial_out_a,
    input wire logic serial_out_b,
    output logic cs_n,
    output logic sclk,
    output logic cal_req,
    output logic serial_config_in,
    output logic [13:0] rx_a,
    output logic [13:0] rx_b
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        cal_req = 1'b0;
        serial_config_in = 1'b1;
        rx_a = 14'h0000;
        rx_b = 14'h0000;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    // mode 1: pin rises with cs fall; mode 2: pin rises mid-conversion
    task automatic frame(input logic [3:0] addr, input logic [11:0] data, input int mode);
        logic [15:0] word;
        word = {addr, data};
        cs_n = 1'b0;
        if (mode == 1) cal_req = 1'b1;
        for (int k = 1; k <= 33; k++) begin
            sclk = 1'b1;
            serial_config_in = (k <= 16) ? word[16-k] : 1'b0;
            tick(4);
            if (k >= 20) begin
                rx_a = {rx_a[12:0], serial_out_a};
                rx_b = {rx_b[12:0], serial_out_b};
            end
            sclk = 1'b0;
            if (mode == 2 && k == 5) cal_req = 1'b1;
            tick(4);
        end
        sclk = 1'b1;
        tick(4);
        cs_n = 1'b1;
        // released line returns to its idle high level
        serial_config_in = 1'b1;
        tick(8);
    endtask : frame
    // pin moves only between conversions, all clocks done; supplies stay up
    task automatic set_cal(input logic v);
        cal_req = v;
        tick(4);
    endtask : set_cal
    // 14-bit code to 12-bit offset: keep sign, drop the next two bits
    function automatic logic [11:0] to_off(input logic [13:0] c);
        return {c[13], c[10:0]};
    endfunction : to_off
endmodule : adoc_host
`default_nettype wire

// ==== tb_top.sv ====
// testbench: serial frames against the calibration control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adoc_pkg::*;
    logic core_clk, reset, cs_n, sclk, cal_req, sdi, so_a, so_b, oe_a, oe_b, short_in;
    logic rv, cc, cd, ci;
    logic [13:0] raw_a, raw_b, res_a, res_b, rx_a, rx_b;
    logic [3:0] pga;
    logic [6:0] g_a, g_b;
    int err_count, num_checks, cyc, n_v, n_c, n_d, n_i, n_s, off_a, off_b;
    adoc_top dut_u (.core_clk(core_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
        .cal_req(cal_req), .serial_config_in(sdi), .raw_code_a(raw_a), .raw_code_b(raw_b),
        .serial_out_a(so_a), .serial_out_a_oe(oe_a), .serial_out_b(so_b),
        .serial_out_b_oe(oe_b), .short_inputs(short_in), .pga_gain_sel(pga),
        .result_a(res_a), .result_b(res_b), .result_valid(rv), .conv_corrupt(cc),
        .cal_done(cd), .cal_inaccurate(ci));
    adoc_host host_u (.core_clk(core_clk), .serial_out_a(so_a), .serial_out_b(so_b),
        .cs_n(cs_n), .sclk(sclk), .cal_req(cal_req), .serial_config_in(sdi),
        .rx_a(rx_a), .rx_b(rx_b));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // pulse counters and hang limit
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        n_v <= n_v + int'(rv === 1'b1);
        n_c <= n_c + int'(cc === 1'b1);
        n_d <= n_d + int'(cd === 1'b1);
        n_i <= n_i + int'(ci === 1'b1);
        n_s <= n_s + int'(short_in === 1'b1);
        if (cyc == 20000) begin
            err_count = err_count + 1;
            finish_test();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    function automatic logic [13:0] corr(input int raw, input int off, input logic [6:0] g);
        int v;
        v = (raw - off) * (g[6] ? 4096 + int'(g[5:0]) : 4096 - int'(g[5:0]));
        v = v >>> 12;
        if (v > 8191) v = 8191;
        if (v < -8192) v = -8192;
        return v[13:0];
    endfunction : corr
    function automatic logic [11:0] enc(input int o);
        return (o < 0) ? {1'b1, 11'(-o)} : {1'b0, 11'(o)};
    endfunction : enc
    // one frame; pulse counts expected: valid, corrupt, cal done, cal inaccurate
    task automatic run(input logic [3:0] a, input logic [11:0] d, input int mode,
                       input int ev, input int ec, input int ed, input int ei);
        int v0, c0, d0, i0, s0;
        v0 = n_v; c0 = n_c; d0 = n_d; i0 = n_i; s0 = n_s;
        host_u.frame(a, d, mode);
        check("valid", n_v - v0, ev);
        check("corrupt", n_c - c0, ec);
        check("cal_done", n_d - d0, ed);
        check("inaccurate", n_i - i0, ei);
        check("shorted", int'(n_s > s0), int'(ed + ei > 0));
        check("oe_a", oe_a, 0);
        check("oe_b", oe_b, 0);
    endtask : run
    task automatic conv(input int ra, input int rb);
        raw_a = 14'(ra);
        raw_b = 14'(rb);
        run(4'h0, 12'h000, 0, 1, 0, 0, 0);
        check("result_a", res_a, corr(ra, off_a, g_a));
        check("result_b", res_b, corr(rb, off_b, g_b));
        check("serial_a", rx_a, corr(ra, off_a, g_a));
        check("serial_b", rx_b, corr(rb, off_b, g_b));
    endtask : conv
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        run(a, d, 0, 1, 0, 0, 0);
    endtask : wr
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        raw_a = 14'h0000;
        raw_b = 14'h0000;
        g_a = 7'h00;
        g_b = 7'h00;
        {err_count, num_checks, off_a, off_b} = '0;
        repeat (2) @(posedge core_clk);
        #1 reset = 1'b0;
        host_u.tick(5);
        check("reset result", res_a, 0);
        check("reset pga", pga, 0);
        conv(100, -50);
        off_a = 10;
        off_b = -5;
        wr(4'h2, host_u.to_off(14'h000A));
        wr(4'h3, enc(-5));
        conv(100, -50);
        conv(8191, -8192);
        g_a = 7'h7F;
        g_b = 7'h3F;
        wr(4'h4, 12'hFE0);
        wr(4'h5, 12'h7E0);
        conv(4000, -50);
        conv(8191, -8192);
        g_a = 7'h00;
        g_b = 7'h00;
        wr(4'h4, 12'h000);
        wr(4'h5, 12'h000);
        off_a = -500;
        wr(4'h2, enc(-2047));
        conv(100, -50);
        raw_a = 14'(30);
        raw_b = 14'(-20);
        run(4'h0, 12'h000, 1, 0, 0, 0, 1);
        raw_a = 14'(40);
        raw_b = 14'(-25);
        run(4'h0, 12'h000, 0, 0, 0, 1, 0);
        off_a = 40;
        off_b = -25;
        host_u.set_cal(1'b0);
        conv(100, -50);
        run(4'h1, 12'h013, 0, 0, 1, 0, 0);
        check("pga", pga, 3);
        raw_a = 14'(12);
        raw_b = 14'(-7);
        run(4'h0, 12'h000, 0, 0, 0, 1, 0);
        off_a = 12;
        off_b = -7;
        wr(4'h1, 12'h205);
        check("readback", rx_a, enc(off_a));
        wr(4'h1, 12'h005);
        conv(100, -50);
        run(4'h0, 12'h000, 2, 0, 1, 0, 0);
        raw_a = 14'(0);
        raw_b = 14'(0);
        run(4'h0, 12'h000, 0, 0, 0, 1, 0);
        off_a = 0;
        off_b = 0;
        host_u.set_cal(1'b0);
        conv(100, -50);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
